// *** core/boot_wdt_cfg_top.sv ***
// Boot selection and hardware watchdog configuration decoder with APB access
`timescale 1ns/100ps
module boot_wdt_cfg_top
(
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic [31:0] cfg_word_i,
  input  wire logic        cfg_valid_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  input  wire logic [31:0] fetch_addr_i,
  input  wire logic        fetch_is_data_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             boot_from_app_o,
  output logic             switching_en_o,
  output logic [31:0]      app_base_o,
  output logic [31:0]      loader_base_o,
  output logic             app_sel_o,
  output logic             access_block_o,
  output logic             force_run_o,
  output logic             force_reset_o,
  output logic             force_low_osc_o,
  output logic             osc_lock_o,
  output logic             wdt_clk_en_o
);
  logic [31:0] cfg_word_reg;
  logic [31:0] cfg_word_next;
  logic        loaded_reg;
  logic [3:0]  ctrl_reg;
  logic [3:0]  ctrl_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pslverr_reg;
  logic        pslverr_next;

  boot_cfg_if cfg_bus();

  // Word is captured at release of reset, not under reset
  assign cfg_word_next = (cfg_valid_i & (~loaded_reg |
    ctrl_reg[boot_cfg_pkg::CTRL_RELOAD_BIT])) ? cfg_word_i : cfg_word_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      cfg_word_reg <= boot_cfg_pkg::CFG_WORD_RESET;
      loaded_reg   <= 1'b0;
    end
    else
    begin
      cfg_word_reg <= cfg_word_next;
      loaded_reg   <= loaded_reg | cfg_valid_i;
    end
  end

  cfg_field_decode u_decode
  (
    .cfg_word_i (cfg_word_reg),
    .cfg        (cfg_bus.src)
  );

  // Lock applies even if software cleared the enable before a reload
  wire losc_eff_w = ctrl_reg[boot_cfg_pkg::CTRL_LOSC_BIT] |
    cfg_bus.hw_wdt_active;

  wdt_force_ctrl u_wdt
  (
    .cfg              (cfg_bus.dst),
    .power_down_i     (ctrl_reg[boot_cfg_pkg::CTRL_PD_BIT]),
    .pd_clk_cfg_i     (ctrl_reg[boot_cfg_pkg::CTRL_PDCLK_BIT]),
    .low_osc_enable_i (losc_eff_w),
    .force_run_o      (force_run_o),
    .force_reset_o    (force_reset_o),
    .force_low_osc_o  (force_low_osc_o),
    .osc_lock_o       (osc_lock_o),
    .wdt_clk_en_o     (wdt_clk_en_o)
  );

  // Memory map: loader window selected by its base when switching
  wire in_loader_win_w = (fetch_addr_i >= boot_cfg_pkg::LOADER_BASE);
  assign boot_from_app_o = cfg_bus.boot_from_app;
  assign switching_en_o  = cfg_bus.switching_en;
  assign app_base_o    = boot_cfg_pkg::APP_BASE;
  assign loader_base_o = boot_cfg_pkg::LOADER_BASE;
  // Both memories reachable while switching, else only boot memory
  assign app_sel_o = cfg_bus.switching_en ?
    ~in_loader_win_w : cfg_bus.boot_from_app;
  // Data reads into the other memory are refused when locked out
  assign access_block_o = fetch_is_data_i & ~cfg_bus.switching_en &
    (in_loader_win_w == cfg_bus.boot_from_app);

  // APB slave: zero wait states, error on unmapped address
  wire setup_w  = psel_i & ~penable_i;
  wire hit_cfg  = (paddr_i == boot_cfg_pkg::ADDR_CFG_WORD);
  wire hit_stat = (paddr_i == boot_cfg_pkg::ADDR_STATUS);
  wire hit_ctrl = (paddr_i == boot_cfg_pkg::ADDR_CONTROL);
  wire mapped_w = hit_cfg | hit_stat | hit_ctrl;
  wire wr_ctrl  = psel_i & penable_i & pwrite_i & hit_ctrl & pstrb_i[0];
  wire [31:0] status_w = {25'h0, cfg_bus.wdt_field,
    cfg_bus.hw_wdt_active, cfg_bus.switching_en,
    cfg_bus.boot_from_app, loaded_reg};

  // Power-down clock config frozen while watchdog forcing is active
  assign ctrl_next = wr_ctrl ? (osc_lock_o ?
    {pwdata_i[3], pwdata_i[2], 1'b1, ctrl_reg[0]} : pwdata_i[3:0])
    : ctrl_reg;
  assign prdata_next = (setup_w & ~pwrite_i) ?
    (hit_cfg ? cfg_word_reg : hit_stat ? status_w :
     hit_ctrl ? {28'h0, ctrl_reg} : 32'h0000_0000) : prdata_reg;
  assign pslverr_next = setup_w ? ~mapped_w : pslverr_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ctrl_reg    <= 4'h2;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready_o  = psel_i & penable_i;
  assign prdata_o  = prdata_reg;
  assign pslverr_o = pslverr_reg & psel_i & penable_i;
endmodule

// *** core/boot_cfg_pkg.sv ***
// Constants for the boot selection and hardware watchdog config decoder
package boot_cfg_pkg;
  localparam logic [7:0]  ADDR_CFG_WORD   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  ADDR_CONTROL    = 8'h08;
  localparam int          BOOT_SEL_HI     = 7;
  localparam int          BOOT_SEL_LO     = 6;
  localparam int          WDT_FIELD_B2    = 31;
  localparam int          WDT_FIELD_B1    = 4;
  localparam int          WDT_FIELD_B0    = 3;
  localparam logic [2:0]  WDT_ACTIVE_CODE = 3'h3;
  localparam logic [31:0] APP_BASE        = 32'h0000_0000;
  localparam logic [31:0] LOADER_BASE     = 32'h0010_0000;
  localparam logic [31:0] CFG_WORD_RESET  = 32'hffff_ffff;
  localparam int          CTRL_PDCLK_BIT  = 0;
  localparam int          CTRL_LOSC_BIT   = 1;
  localparam int          CTRL_PD_BIT     = 2;
  localparam int          CTRL_RELOAD_BIT = 3;
endpackage

// *** core/boot_cfg_if.sv ***
// Interface carrying the decoded configuration between internal modules
`timescale 1ns/100ps
interface boot_cfg_if;
  logic       boot_from_app;
  logic       switching_en;
  logic       hw_wdt_active;
  logic [2:0] wdt_field;
  modport src
  (
    output boot_from_app,
    output switching_en,
    output hw_wdt_active,
    output wdt_field
  );
  modport dst
  (
    input  boot_from_app,
    input  switching_en,
    input  hw_wdt_active,
    input  wdt_field
  );
endinterface

// *** core/cfg_field_decode.sv ***
// Field decode of the latched user boot configuration word
`timescale 1ns/100ps
module cfg_field_decode
(
  input  wire logic [31:0] cfg_word_i,
  boot_cfg_if.src          cfg
);
  wire [2:0] wdt_field_w;

  assign wdt_field_w = {cfg_word_i[boot_cfg_pkg::WDT_FIELD_B2],
                        cfg_word_i[boot_cfg_pkg::WDT_FIELD_B1],
                        cfg_word_i[boot_cfg_pkg::WDT_FIELD_B0]};
  assign cfg.wdt_field = wdt_field_w;
  // Only the upper select bit chooses the boot memory
  assign cfg.boot_from_app =
    cfg_word_i[boot_cfg_pkg::BOOT_SEL_HI];
  // Lower bit 0 keeps switching on in both boot choices
  assign cfg.switching_en =
    ~cfg_word_i[boot_cfg_pkg::BOOT_SEL_LO];
  assign cfg.hw_wdt_active =
    (wdt_field_w == boot_cfg_pkg::WDT_ACTIVE_CODE);
endmodule

// *** core/wdt_force_ctrl.sv ***
// Watchdog forcing and clock gating from the decoded configuration
`timescale 1ns/100ps
module wdt_force_ctrl
(
  boot_cfg_if.dst          cfg,
  input  wire logic        power_down_i,
  input  wire logic        pd_clk_cfg_i,
  input  wire logic        low_osc_enable_i,
  output logic             force_run_o,
  output logic             force_reset_o,
  output logic             force_low_osc_o,
  output logic             osc_lock_o,
  output logic             wdt_clk_en_o
);
  wire pd_gate_w;

  assign force_run_o     = cfg.hw_wdt_active;
  assign force_reset_o   = cfg.hw_wdt_active;
  assign force_low_osc_o = cfg.hw_wdt_active;
  assign osc_lock_o      = cfg.hw_wdt_active;
  // Power-down: cfg bit 0 keeps clock, else oscillator enable gates it
  assign pd_gate_w = ~pd_clk_cfg_i | low_osc_enable_i;
  // Without hardware forcing software enable alone runs the clock
  assign wdt_clk_en_o = cfg.hw_wdt_active ?
    (power_down_i ? pd_gate_w : 1'b1) : low_osc_enable_i;
endmodule

// *** tb/boot_wdt_cfg_assertions.sv ***
// Port assertions for the boot and watchdog config decoder
`timescale 1ns/100ps
module boot_wdt_cfg_assertions
(
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] fetch_addr_i,
  input  wire logic        fetch_is_data_i,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  input  wire logic        boot_from_app_o,
  input  wire logic        switching_en_o,
  input  wire logic [31:0] app_base_o,
  input  wire logic [31:0] loader_base_o,
  input  wire logic        app_sel_o,
  input  wire logic        access_block_o,
  input  wire logic        force_run_o,
  input  wire logic        force_reset_o,
  input  wire logic        force_low_osc_o,
  input  wire logic        osc_lock_o,
  input  wire logic        wdt_clk_en_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  chk_ready_access: assert property (pready_o == (psel_i && penable_i))
    else $error("pready not tied to access phase");
  chk_base_fixed: assert property (
    app_base_o == 32'h0000_0000 && loader_base_o == 32'h0010_0000)
    else $error("memory bases wrong");
  chk_forced_pair: assert property (force_run_o == force_reset_o)
    else $error("run and reset forcing differ");
  chk_forced_osc: assert property (
    force_run_o |-> force_low_osc_o && osc_lock_o)
    else $error("low oscillator not forced");
  chk_unforced_free: assert property (
    !force_run_o |-> !force_low_osc_o && !osc_lock_o)
    else $error("forcing without active code");
  chk_app_window: assert property (
    app_sel_o == (switching_en_o ? (fetch_addr_i < 32'h0010_0000) :
    boot_from_app_o))
    else $error("memory select wrong");
  chk_hidden_read: assert property (access_block_o ==
    (fetch_is_data_i && !switching_en_o &&
    ((fetch_addr_i >= 32'h0010_0000) == boot_from_app_o)))
    else $error("hidden memory read not refused");
  chk_forced_clock: assert property (
    force_run_o |-> wdt_clk_en_o)
    else $error("forced watchdog clock stopped");
  chk_unmapped_err: assert property (
    psel_i && penable_i && paddr_i > 8'h08 |-> pslverr_o)
    else $error("unmapped access not refused");
  chk_err_gated: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access phase");
  cover property (force_run_o);
  cover property (access_block_o);
  cover property (pslverr_o);
endmodule
bind boot_wdt_cfg_top boot_wdt_cfg_assertions u_chk (.*);

// *** tb/cpu_fetch_model.sv ***
// CPU fetch side model presenting addresses to the decoder
`timescale 1ns/100ps
module cpu_fetch_model
(
  input  wire logic        clk_i,
  input  wire logic [31:0] want_addr_i,
  input  wire logic        want_data_i,
  output logic [31:0]      fetch_addr_o,
  output logic             fetch_is_data_o
);
  // Registered, so an address lands one edge after it is asked for
  always_ff @(posedge clk_i)
  begin
    fetch_addr_o    <= want_addr_i;
    fetch_is_data_o <= want_data_i;
  end
endmodule

// *** tb/boot_and_wdt_config_decode_tb_top.sv ***
// Self-checking bench for the boot and watchdog config decoder
`timescale 1ns/100ps
module boot_and_wdt_config_decode_tb_top;
  logic        core_clk_i, srst_i, cfg_valid_i, psel_i, penable_i;
  logic        pwrite_i, fetch_is_data_i, want_data, smp, fact, en;
  logic        pready_o, pslverr_o, boot_from_app_o, switching_en_o;
  logic        app_sel_o, access_block_o, force_run_o, force_reset_o;
  logic        force_low_osc_o, osc_lock_o, wdt_clk_en_o;
  logic [7:0]  paddr_i;
  logic [3:0]  pstrb_i;
  logic [2:0]  f;
  logic [31:0] cfg_word_i, pwdata_i, fetch_addr_i, prdata_o, app_base_o;
  logic [31:0] loader_base_o, want_addr, w, ctl, rnd;
  logic [31:0] expq[$];
  int          n_errors, compares;
  boot_wdt_cfg_top dut (.*);
  cpu_fetch_model u_cpu (.clk_i(core_clk_i), .want_addr_i(want_addr),
    .want_data_i(want_data), .fetch_addr_o(fetch_addr_i),
    .fetch_is_data_o(fetch_is_data_i));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int k;
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'h1;
    k = 0;
    do @(posedge core_clk_i); while (pready_o !== 1'h1 && ++k < 20);
    if (k == 20)
    begin
      n_errors++;
      results();
    end
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    expq.push_back(e);
    apb(1'h0, a, 32'h0);
  endtask
  // Results are matched to notes strictly in issue order
  always @(posedge core_clk_i)
  begin
    if (psel_i && penable_i && pready_o === 1'h1 && !pwrite_i)
      check("prdata", prdata_o, expq.pop_front());
    if (smp)
      check("decode", {23'h0, boot_from_app_o, switching_en_o, force_run_o,
        force_reset_o, force_low_osc_o, osc_lock_o, wdt_clk_en_o,
        app_sel_o, access_block_o}, expq.pop_front());
  end
  initial
  begin
    core_clk_i = 1'h0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    {srst_i, cfg_valid_i, pstrb_i, rnd} = {1'h1, 1'h1, 4'hf, 32'h5f};
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, smp} = '0;
    {cfg_word_i, want_addr, want_data, n_errors, compares} = '0;
    repeat (16) @(posedge core_clk_i);
    srst_i <= 1'h0;
    for (int i = 0; i < 8; i++)
    begin
      rnd = xs(rnd);
      w = rnd;
      w[7:6] = i[1:0];
      f = (i < 4) ? 3'h3 : ((rnd[2:0] == 3'h3) ? 3'h7 : rnd[2:0]);
      {w[31], w[4], w[3]} = f;
      fact = (f == 3'h3);
      cfg_word_i <= w;
      apb(1'h1, 8'h08, 32'ha);
      ctl = xs(rnd) & 32'h7;
      apb(1'h1, 8'h08, ctl);
      apb(1'h1, 8'h00, ~w);
      rd(8'h00, w);
      rd(8'h04, {25'h0, f, fact, ~w[6], w[7], 1'h1});
      rd(8'h0c, 32'h0);
      want_addr <= rnd & 32'h001f_ffff;
      want_data <= rnd[31];
      repeat (2) @(posedge core_clk_i);
      // Forcing pins the oscillator enable high, so the gate stays open
      en = fact ? 1'h1 : ctl[1];
      expq.push_back({23'h0, w[7], ~w[6], {4{fact}}, en,
        (w[6] ? w[7] : (want_addr < 32'h0010_0000)), want_data & w[6] &
        (w[7] != (want_addr < 32'h0010_0000))});
      smp <= 1'h1;
      @(posedge core_clk_i);
      smp <= 1'h0;
      @(posedge core_clk_i);
      $display("test %0d done", i);
    end
    results();
  end
endmodule
